//--- common/sbc_pkg.sv
// Shared constants and decode helpers for the system-bus command host
package sbc_pkg;
	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int CMD_W = 4;
	localparam int ADDR_W = 36;
	localparam int DATA_W = 128;
	localparam int LW_W = 4;
	localparam int UNITS = 4;
	localparam int UNIT_CNT_W = 3;
	localparam int SLOTS = 2;
	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [3:0] CMD_IDLE = 4'h0;
	localparam logic [3:0] CMD_RES_LOAD = 4'h1;
	localparam logic [3:0] CMD_PF_HINT = 4'h2;
	localparam logic [3:0] CMD_PF_HINT_MOD = 4'h3;
	localparam logic [3:0] CMD_BARRIER = 4'h4;
	localparam logic [3:0] CMD_MARK_MOD = 4'h5;
	localparam logic [3:0] CMD_WB = 4'h6;
	localparam logic [3:0] CMD_COND_WB = 4'h7;
	localparam logic [3:0] CMD_EVICT = 4'hC;
	localparam logic [3:0] CMD_SPARE = 4'hD;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int SYSCLK_PERIOD_NS = 40;
	localparam int SYSCLK_RATIO_I = SYSCLK_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [3:0] SYSCLK_RATIO = SYSCLK_RATIO_I[3:0];
	localparam logic [3:0] SYSCLK_HALF = SYSCLK_RATIO_I[4:1];
	localparam logic [1:0] FILL_LEAD_TICKS = 2'h2;
	// ----------------------------------------------------------------
	// Field positions in the 39:4 address
	// ----------------------------------------------------------------
	localparam int SUB_LSB = 0;
	localparam int SUB_MSB = 1;
	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic logic is_block_req(input logic [3:0] c);
		return c[3] && (c[2:1] != 2'b10);
	endfunction : is_block_req

	function automatic logic is_write_req(input logic [3:0] c);
		return c[3:1] == 3'b101;
	endfunction : is_write_req

	function automatic logic is_data_cmd(input logic [3:0] c);
		return (c == CMD_WB) || (c == CMD_COND_WB) || (c == CMD_EVICT);
	endfunction : is_data_cmd
endpackage : sbc_pkg

//--- design/sbc_sysclk_div.sv
// System clock divider with a one-cycle rising-edge enable
`timescale 1ns/1ns
module sbc_sysclk_div (
	input wire logic clock_i,
	input wire logic rst_b_i,
	output logic tick_o,
	output logic sysclk_o
);
	logic [3:0] cnt_r;
	logic sysclk_r;

	// ----------------------------------------------------------------
	// Divider
	// ----------------------------------------------------------------
	assign tick_o = (cnt_r == sbc_pkg::SYSCLK_RATIO - 4'h1);
	assign sysclk_o = sysclk_r;

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_r <= 4'h0;
		end else if (tick_o) begin
			cnt_r <= 4'h0;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sysclk_r <= 1'b0;
		end else if (tick_o) begin
			sysclk_r <= 1'b1;
		end else if (cnt_r == sbc_pkg::SYSCLK_HALF - 4'h1) begin
			sysclk_r <= 1'b0;
		end
	end
endmodule : sbc_sysclk_div

//--- design/sbc_fill_seq.sv
// Fill sequencer: fill request lead, data delivery and tag status
`timescale 1ns/1ns
module sbc_fill_seq (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic tick_i,
	input wire logic start_i,
	input wire logic slot_i,
	input wire logic shared_i,
	input wire logic modify_i,
	input wire logic [127:0] fill_data_i,
	input wire logic fill_valid_i,
	output logic fill_ready_o,
	output logic fill_o,
	output logic fill_id_o,
	output logic cache_idle_request_o,
	output logic tag_shared_o,
	output logic tag_modified_o,
	output logic tag_ctl_par_o,
	output logic [127:0] data_o,
	output logic data_oe_b_o,
	output logic dack_o,
	output logic busy_o,
	output logic done_o,
	output logic done_slot_o
);
	typedef enum logic [2:0] {
		F_IDLE = 3'b001,
		F_LEAD = 3'b010,
		F_XFER = 3'b100
	} sbc_fill_e;

	sbc_fill_e state_r;
	logic [1:0] lead_r;
	logic [2:0] cnt_r;
	logic slot_r;

	assign busy_o = (state_r != F_IDLE);
	assign fill_ready_o = (state_r == F_XFER) && tick_i && !dack_o &&
		(cnt_r != 3'(sbc_pkg::UNITS));
	assign done_slot_o = slot_r;

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_r <= F_IDLE;
			lead_r <= 2'h0;
			cnt_r <= 3'h0;
			fill_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			unique case (state_r)
				F_IDLE: begin
					if (start_i) begin
						state_r <= F_LEAD;
						lead_r <= 2'h0;
						cnt_r <= 3'h0;
					end
				end
				F_LEAD: begin
					if (tick_i && !fill_o) begin
						fill_o <= 1'b1;
					end else if (tick_i && lead_r == sbc_pkg::FILL_LEAD_TICKS) begin
						fill_o <= 1'b0;
						state_r <= F_XFER;
					end else if (tick_i) begin
						lead_r <= lead_r + 2'h1;
					end
				end
				F_XFER: begin
					if (fill_ready_o && fill_valid_i) begin
						cnt_r <= cnt_r + 3'h1;
					end else if (tick_i && !dack_o &&
						cnt_r == 3'(sbc_pkg::UNITS)) begin
						state_r <= F_IDLE;
						done_o <= 1'b1;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Data bus and data_ack
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			data_o <= 128'h0;
			data_oe_b_o <= 1'b1;
			dack_o <= 1'b0;
		end else if (fill_ready_o && fill_valid_i) begin
			data_o <= fill_data_i;
			data_oe_b_o <= 1'b0;
			dack_o <= 1'b1;
		end else if (tick_i) begin
			dack_o <= 1'b0;
			if (state_r != F_XFER || cnt_r == 3'(sbc_pkg::UNITS)) begin
				data_oe_b_o <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Tag status held for the whole fill
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			slot_r <= 1'b0;
			fill_id_o <= 1'b0;
			tag_shared_o <= 1'b0;
			tag_modified_o <= 1'b0;
			tag_ctl_par_o <= 1'b0;
			cache_idle_request_o <= 1'b0;
		end else if (state_r == F_IDLE && start_i) begin
			slot_r <= slot_i;
			fill_id_o <= slot_i;
			tag_shared_o <= shared_i;
			tag_modified_o <= modify_i;
			tag_ctl_par_o <= shared_i ^ modify_i;
			cache_idle_request_o <= 1'b1;
		end else if (done_o) begin
			cache_idle_request_o <= 1'b0;
		end
	end
endmodule : sbc_fill_seq

//--- design/sbc_host.sv
// System-side host for processor-initiated bus commands and fills
//
// Overview of operation
// - Owner of the command lines drives idle_command when nothing is queued.
// - Writeback: unit per data_ack, command_ack may precede the last unit; here command_ack follows the last data_ack.
// - Conditional writeback is a writeback the system may refuse.
// - System substitutes address bits 5:4 of evicted notice from block request.
// - System acknowledges immediately or at latest with final fill data_ack.
// - System asserts tag_modified during fills for block_request_for_write.
// - fill_request and fill_select lead fill data by at least two sysclk periods.
// - System raises cache_idle_request so the cache is idle for fills.
// - Device tristates at N+1; system then drives data and data_ack.
// - System holds shared, modified and parity tag bits through the fill.
`timescale 1ns/1ns
module sbc_host (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic [3:0] cmd_i,
	output logic [3:0] cmd_o,
	output logic cmd_oe_b_o,
	input wire logic [35:0] addr_i,
	input wire logic victim_waiting_i,
	input wire logic [3:0] longword_valid_i,
	input wire logic [127:0] data_i,
	output logic [127:0] data_o,
	output logic data_oe_b_o,
	output logic sysclk_o,
	output logic command_ack_o,
	output logic data_ack_o,
	output logic conditional_fail_o,
	output logic fill_request_o,
	output logic fill_select_o,
	output logic cache_idle_request_o,
	output logic tag_shared_o,
	output logic tag_modified_o,
	output logic tag_ctl_par_o,
	output logic req_valid_o,
	output logic [3:0] req_cmd_o,
	output logic [35:0] req_addr_o,
	output logic req_istream_o,
	output logic [1:0] pending_o,
	output logic [127:0] wr_data_o,
	output logic wr_valid_o,
	output logic wr_last_o,
	input wire logic wr_ready_i,
	input wire logic cond_fail_i,
	input wire logic fill_start_i,
	input wire logic fill_slot_i,
	input wire logic fill_shared_i,
	output logic fill_busy_o,
	input wire logic [127:0] fill_data_i,
	input wire logic fill_valid_i,
	output logic fill_ready_o
);
	typedef enum logic [2:0] {
		C_IDLE = 3'b001,
		C_DATA = 3'b010,
		C_ACK = 3'b100
	} sbc_cmd_e;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	sbc_cmd_e state_r;
	logic tick;
	logic [3:0] cmd_r;
	logic [2:0] unit_cnt_r;
	logic wb_dack_r;
	logic fill_dack;
	logic [1:0] pending_r;
	logic [1:0] modify_r;
	logic vb_r;
	logic [1:0] vb_bits_r;
	logic fill_done;
	logic fill_done_slot;
	logic fill_go;
	logic take_unit;
	logic [35:0] addr_fix;

	// ----------------------------------------------------------------
	// System clock
	// ----------------------------------------------------------------
	sbc_sysclk_div u_div (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.tick_o(tick),
		.sysclk_o(sysclk_o)
	);

	// ----------------------------------------------------------------
	// Command lines are never taken over by this host
	// ----------------------------------------------------------------
	assign cmd_o = sbc_pkg::CMD_IDLE;
	assign cmd_oe_b_o = 1'b1;

	// ----------------------------------------------------------------
	// Command state machine
	// ----------------------------------------------------------------
	assign take_unit = (state_r == C_DATA) && tick && !wb_dack_r &&
		wr_ready_i && (unit_cnt_r != 3'(sbc_pkg::UNITS));

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_r <= C_IDLE;
			cmd_r <= sbc_pkg::CMD_IDLE;
		end else if (tick) begin
			unique case (state_r)
				C_IDLE: begin
					cmd_r <= cmd_i;
					if (sbc_pkg::is_data_cmd(cmd_i)) begin
						state_r <= C_DATA;
					end else if (cmd_i != sbc_pkg::CMD_IDLE &&
						cmd_i != sbc_pkg::CMD_SPARE) begin
						state_r <= C_ACK;
					end
				end
				C_DATA: begin
					if (!wb_dack_r && unit_cnt_r == 3'(sbc_pkg::UNITS)) begin
						state_r <= C_ACK;
					end
				end
				C_ACK: begin
					state_r <= C_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Unit counter for writeback and victim data
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			unit_cnt_r <= 3'h0;
		end else if (tick && state_r == C_IDLE) begin
			unit_cnt_r <= 3'h0;
		end else if (take_unit) begin
			unit_cnt_r <= unit_cnt_r + 3'h1;
		end
	end

	// ----------------------------------------------------------------
	// data_ack for outbound data, one sysclk period per unit
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wb_dack_r <= 1'b0;
		end else if (take_unit) begin
			wb_dack_r <= 1'b1;
		end else if (tick) begin
			wb_dack_r <= 1'b0;
		end
	end

	assign data_ack_o = wb_dack_r | fill_dack;

	// ----------------------------------------------------------------
	// Outbound data to the memory side
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_data_o <= 128'h0;
			wr_valid_o <= 1'b0;
			wr_last_o <= 1'b0;
		end else begin
			wr_valid_o <= take_unit;
			if (take_unit) begin
				wr_data_o <= data_i;
				wr_last_o <= (unit_cnt_r == 3'(sbc_pkg::UNITS - 1));
			end
		end
	end

	// ----------------------------------------------------------------
	// command_ack and conditional_fail
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			command_ack_o <= 1'b0;
			conditional_fail_o <= 1'b0;
		end else if (tick) begin
			command_ack_o <= 1'b0;
			conditional_fail_o <= 1'b0;
			if (state_r == C_IDLE && cmd_i != sbc_pkg::CMD_IDLE &&
				cmd_i != sbc_pkg::CMD_SPARE &&
				!sbc_pkg::is_data_cmd(cmd_i)) begin
				command_ack_o <= 1'b1;
			end else if (state_r == C_DATA && !wb_dack_r &&
				unit_cnt_r == 3'(sbc_pkg::UNITS)) begin
				command_ack_o <= 1'b1;
				conditional_fail_o <= (cmd_r == sbc_pkg::CMD_COND_WB) &&
					cond_fail_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// Victim address fix-up for victim-buffer mode
	// ----------------------------------------------------------------
	always_comb begin
		addr_fix = addr_i;
		if (cmd_i == sbc_pkg::CMD_EVICT && vb_r) begin
			addr_fix[sbc_pkg::SUB_MSB:sbc_pkg::SUB_LSB] = vb_bits_r;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			vb_r <= 1'b0;
			vb_bits_r <= 2'h0;
		end else if (tick && state_r == C_IDLE) begin
			if (sbc_pkg::is_block_req(cmd_i)) begin
				vb_r <= victim_waiting_i;
				vb_bits_r <= addr_i[sbc_pkg::SUB_MSB:sbc_pkg::SUB_LSB];
			end else if (cmd_i == sbc_pkg::CMD_EVICT) begin
				vb_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Request report to the memory side
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			req_valid_o <= 1'b0;
			req_cmd_o <= sbc_pkg::CMD_IDLE;
			req_addr_o <= 36'h0;
			req_istream_o <= 1'b0;
		end else begin
			req_valid_o <= 1'b0;
			if (tick && state_r == C_IDLE &&
				cmd_i != sbc_pkg::CMD_IDLE &&
				cmd_i != sbc_pkg::CMD_SPARE) begin
				req_valid_o <= 1'b1;
				req_cmd_o <= cmd_i;
				req_addr_o <= addr_fix;
				req_istream_o <= (longword_valid_i == 4'h0);
			end
		end
	end

	// ----------------------------------------------------------------
	// Outstanding block requests, one per slot
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pending_r <= 2'h0;
			modify_r <= 2'h0;
		end else begin
			for (int i = 0; i < sbc_pkg::SLOTS; i++) begin
				if (tick && state_r == C_IDLE &&
					sbc_pkg::is_block_req(cmd_i) && cmd_i[0] == i[0]) begin
					pending_r[i] <= 1'b1;
					modify_r[i] <= sbc_pkg::is_write_req(cmd_i);
				end else if (fill_done && fill_done_slot == i[0]) begin
					pending_r[i] <= 1'b0;
				end
			end
		end
	end

	assign pending_o = pending_r;

	// ----------------------------------------------------------------
	// Fill launch
	// ----------------------------------------------------------------
	assign fill_go = fill_start_i && !fill_busy_o && pending_r[fill_slot_i];

	sbc_fill_seq u_fill (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.tick_i(tick),
		.start_i(fill_go),
		.slot_i(fill_slot_i),
		.shared_i(fill_shared_i),
		.modify_i(modify_r[fill_slot_i]),
		.fill_data_i(fill_data_i),
		.fill_valid_i(fill_valid_i),
		.fill_ready_o(fill_ready_o),
		.fill_o(fill_request_o),
		.fill_id_o(fill_select_o),
		.cache_idle_request_o(cache_idle_request_o),
		.tag_shared_o(tag_shared_o),
		.tag_modified_o(tag_modified_o),
		.tag_ctl_par_o(tag_ctl_par_o),
		.data_o(data_o),
		.data_oe_b_o(data_oe_b_o),
		.dack_o(fill_dack),
		.busy_o(fill_busy_o),
		.done_o(fill_done),
		.done_slot_o(fill_done_slot)
	);
endmodule : sbc_host

//--- tb/sbc_host_checker.sv
// Concurrent checks on the system-bus command host ports
`timescale 1ns/1ns
module sbc_host_checker (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic [3:0] cmd_o,
	input wire logic cmd_oe_b_o,
	input wire logic data_oe_b_o,
	input wire logic command_ack_o,
	input wire logic data_ack_o,
	input wire logic conditional_fail_o,
	input wire logic fill_request_o,
	input wire logic fill_select_o,
	input wire logic cache_idle_request_o,
	input wire logic tag_shared_o,
	input wire logic tag_modified_o,
	input wire logic tag_ctl_par_o,
	input wire logic req_valid_o,
	input wire logic [3:0] req_cmd_o,
	input wire logic wr_valid_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	// ----------------------------------------------------------------
	// Sequences
	// ----------------------------------------------------------------
	sequence s_period(s);
		s [*4] ##1 !s;
	endsequence
	sequence s_lead;
		(fill_request_o && data_oe_b_o) [*8];
	endsequence
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	chk_cmd_idle: assert property (cmd_o == 4'h0 && cmd_oe_b_o)
		else $error("command lines not idle");
	chk_cack_span: assert property (
		$rose(command_ack_o) |-> s_period(command_ack_o))
		else $error("command ack not one system period");
	chk_dack_span: assert property (
		$rose(data_ack_o) |-> s_period(data_ack_o))
		else $error("data ack not one system period");
	chk_req_ack: assert property (
		$rose(req_valid_o) && !(req_cmd_o inside {4'h6, 4'h7, 4'hC})
		|-> command_ack_o)
		else $error("request not acknowledged at once");
	chk_cfail_ack: assert property (
		conditional_fail_o |-> command_ack_o)
		else $error("refusal without command ack");
	chk_unit_dack: assert property ($rose(wr_valid_o) |-> data_ack_o)
		else $error("unit taken without data ack");
	chk_fill_lead: assert property (
		$rose(fill_request_o) |-> s_lead)
		else $error("fill data sooner than two periods");
	chk_fill_idle: assert property (
		fill_request_o |-> cache_idle_request_o)
		else $error("fill without cache idle request");
	chk_sel_hold: assert property (
		fill_request_o && $past(fill_request_o) |-> $stable(fill_select_o))
		else $error("fill select moved");
	chk_tag_par: assert property (
		cache_idle_request_o |->
		tag_ctl_par_o == (tag_shared_o ^ tag_modified_o))
		else $error("tag parity wrong");
	chk_tag_hold: assert property (
		cache_idle_request_o && $past(cache_idle_request_o) |->
		$stable({tag_shared_o, tag_modified_o}))
		else $error("tag bits moved in fill");
endmodule : sbc_host_checker

bind sbc_host sbc_host_checker i_chk (.clock_i, .rst_b_i, .cmd_o,
	.cmd_oe_b_o, .data_oe_b_o, .command_ack_o, .data_ack_o,
	.conditional_fail_o, .fill_request_o, .fill_select_o,
	.cache_idle_request_o, .tag_shared_o, .tag_modified_o,
	.tag_ctl_par_o, .req_valid_o, .req_cmd_o, .wr_valid_o);

//--- tb/sbc_dev_model.sv
// Processor-side model that issues commands and takes fill data
`timescale 1ns/1ns
module sbc_dev_model (
	input wire logic clock_i,
	input wire logic sysclk_i,
	input wire logic command_ack_i,
	input wire logic data_ack_i,
	input wire logic conditional_fail_i,
	input wire logic [127:0] host_data_i,
	input wire logic host_oe_b_i,
	output logic [3:0] cmd_o,
	output logic [35:0] addr_o,
	output logic victim_waiting_o,
	output logic [3:0] longword_valid_o,
	output logic [127:0] data_o
);
	logic cq, dq, fq, oq;
	logic [127:0] hq;
	logic [127:0] got[$];
	function automatic logic [127:0] unit(input int k);
		return {32{4'(k + 1)}};
	endfunction : unit
	initial begin
		cmd_o = 4'h0;
		addr_o = 36'h0;
		victim_waiting_o = 1'b0;
		longword_valid_o = 4'h0;
		data_o = 128'h0;
	end
	// Values as they stood just before each clock edge
	always @(posedge clock_i) begin
		cq <= command_ack_i;
		dq <= data_ack_i;
		fq <= conditional_fail_i;
		hq <= host_data_i;
		oq <= host_oe_b_i;
	end
	// Fill unit taken at a system edge with data ack
	always @(posedge sysclk_i) begin
		if (dq && !oq)
			got.push_back(hq);
	end
	task automatic send(input logic [3:0] c, input logic [35:0] a,
		input logic [3:0] lw, input logic vw, output logic ok,
		output logic cf);
		int u;
		ok = 1'b0;
		cf = 1'b0;
		u = 0;
		@(posedge sysclk_i);
		#1;
		cmd_o = c;
		addr_o = a;
		longword_valid_o = lw;
		victim_waiting_o = vw;
		data_o = unit(0);
		for (int n = 0; n < 40 && !ok; n++) begin
			@(posedge sysclk_i);
			ok = cq;
			cf = fq;
			if (dq && u < 3) begin
				u++;
				#1;
				data_o = unit(u);
			end
		end
		#1;
		cmd_o = 4'h0;
		addr_o = ~a;
		victim_waiting_o = 1'b0;
		data_o = ~data_o;
	endtask : send
endmodule : sbc_dev_model

//--- tb/sbc_host_tb.sv
// Self-checking bench for the system-bus command host
`timescale 1ns/1ns
module sbc_host_tb;
	logic clock_i, rst_b_i, cmd_oe_b_o, victim_waiting_i, data_oe_b_o;
	logic sysclk_o, command_ack_o, data_ack_o, conditional_fail_o;
	logic fill_request_o, fill_select_o, cache_idle_request_o;
	logic tag_shared_o, tag_modified_o, tag_ctl_par_o, req_valid_o;
	logic req_istream_o, wr_valid_o, wr_last_o, wr_ready_i, cond_fail_i;
	logic fill_start_i, fill_slot_i, fill_shared_i, fill_busy_o;
	logic fill_valid_i, fill_ready_o;
	logic [3:0] cmd_i, cmd_o, longword_valid_i, req_cmd_o;
	logic [35:0] addr_i, req_addr_o;
	logic [1:0] pending_o;
	logic [127:0] data_i, data_o, wr_data_o, fill_data_i;
	int mismatches = 0;
	int comparisons = 0;
	int rq_n = 0;
	int last_n = 0;
	logic [3:0] rq_cmd;
	logic [35:0] rq_addr;
	logic rq_is;
	logic [127:0] wr_q[$];
	sbc_host i_dut (.clock_i, .rst_b_i, .cmd_i, .cmd_o, .cmd_oe_b_o,
		.addr_i, .victim_waiting_i, .longword_valid_i, .data_i, .data_o,
		.data_oe_b_o, .sysclk_o, .command_ack_o, .data_ack_o,
		.conditional_fail_o, .fill_request_o, .fill_select_o,
		.cache_idle_request_o, .tag_shared_o, .tag_modified_o,
		.tag_ctl_par_o, .req_valid_o, .req_cmd_o, .req_addr_o,
		.req_istream_o, .pending_o, .wr_data_o, .wr_valid_o, .wr_last_o,
		.wr_ready_i, .cond_fail_i, .fill_start_i, .fill_slot_i,
		.fill_shared_i, .fill_busy_o, .fill_data_i, .fill_valid_i,
		.fill_ready_o);
	sbc_dev_model i_dev (.clock_i, .sysclk_i(sysclk_o),
		.command_ack_i(command_ack_o), .data_ack_i(data_ack_o),
		.conditional_fail_i(conditional_fail_o), .host_data_i(data_o),
		.host_oe_b_i(data_oe_b_o), .cmd_o(cmd_i), .addr_o(addr_i),
		.victim_waiting_o(victim_waiting_i),
		.longword_valid_o(longword_valid_i), .data_o(data_i));
	always #5 clock_i = ~clock_i;
	// ----------------------------------------------------------------
	// Monitors and helpers
	// ----------------------------------------------------------------
	always @(posedge clock_i) begin
		if (req_valid_o) begin
			rq_n++;
			rq_cmd = req_cmd_o;
			rq_addr = req_addr_o;
			rq_is = req_istream_o;
		end
		if (wr_valid_o)
			wr_q.push_back(wr_data_o);
		if (wr_valid_o && wr_last_o)
			last_n++;
	end
	task automatic check(input logic [127:0] got, input logic [127:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask : check
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		check(cmd_o, 4'h0);
		check(cmd_oe_b_o, 1'b1);
		check(data_oe_b_o, 1'b1);
		check(command_ack_o, 1'b0);
	endtask : t_reset
	task automatic t_plain();
		logic ok, cf;
		for (int c = 1; c < 6; c++) begin
			i_dev.send(4'(c), 36'h0_0000_0100, 4'hF, 1'b0, ok, cf);
			check(ok, 1'b1);
			check(rq_n, c);
			check(rq_cmd, 4'(c));
		end
		i_dev.send(4'hD, 36'h0_0000_0200, 4'hF, 1'b0, ok, cf);
		check(ok, 1'b0);
		check(rq_n, 5);
	endtask : t_plain
	task automatic t_wb();
		logic ok, cf;
		for (int c = 6; c < 8; c++) begin
			wr_q.delete();
			last_n = 0;
			wr_ready_i = 1'b0;
			cond_fail_i = 1'b1;
			fork
				begin
					repeat (30) @(posedge clock_i);
					#1;
					wr_ready_i = 1'b1;
				end
			join_none
			i_dev.send(4'(c), 36'h0_ABCD_0040, 4'hF, 1'b0, ok, cf);
			check(ok, 1'b1);
			check(cf, c == 7);
			check(wr_q.size(), 4);
			check(last_n, 1);
			for (int k = 0; k < 4; k++)
				check(wr_q[k], i_dev.unit(k));
		end
	endtask : t_wb
	task automatic t_fill(input logic [3:0] c, input logic sh);
		logic ok, cf;
		int k, n;
		i_dev.send(c, 36'h0_0000_1230, 4'hF, 1'b0, ok, cf);
		i_dev.got.delete();
		fill_slot_i = c[0];
		fill_shared_i = sh;
		fill_start_i = 1'b1;
		@(posedge clock_i);
		#1;
		fill_start_i = 1'b0;
		check(fill_busy_o, 1'b1);
		check(fill_select_o, c[0]);
		check(tag_modified_o, c[3:1] == 3'b101);
		check(tag_shared_o, sh);
		k = 0;
		for (n = 0; n < 400 && k < 4; n++) begin
			fill_valid_i = !(k == 2 && n < 60);
			fill_data_i = i_dev.unit(k + 4);
			@(posedge clock_i);
			if (fill_valid_i && fill_ready_o)
				k++;
			#1;
		end
		fill_valid_i = 1'b0;
		if (k < 4) begin
			mismatches++;
			close_out();
		end
		for (n = 0; n < 200 && fill_busy_o !== 1'b0; n++) begin
			@(posedge clock_i);
			#1;
		end
		if (n == 200) begin
			mismatches++;
			close_out();
		end
		@(posedge clock_i);
		#1;
		check(i_dev.got.size(), 4);
		for (int j = 0; j < 4; j++)
			check(i_dev.got[j], i_dev.unit(j + 4));
		check(pending_o[c[0]], 1'b0);
		check(data_oe_b_o, 1'b1);
		check(cache_idle_request_o, 1'b0);
	endtask : t_fill
	task automatic t_blk();
		logic ok, cf;
		logic [3:0] c;
		logic [3:0] lw;
		for (int i = 0; i < 6; i++) begin
			c = (i < 4) ? 4'(8 + i) : 4'(10 + i);
			lw = i[0] ? 4'h0 : 4'h9;
			i_dev.send(c, {32'h0000_5A50, c}, lw, 1'b0, ok, cf);
			check(ok, 1'b1);
			check(rq_cmd, c);
			check(rq_addr, {32'h0000_5A50, c});
			check(rq_is, lw == 4'h0);
			check(pending_o[c[0]], 1'b1);
		end
	endtask : t_blk
	task automatic t_victim(input logic vb);
		logic ok, cf;
		logic [3:0] c;
		logic [35:0] a;
		wr_q.delete();
		for (int s = 0; s < 2; s++) begin
			c = (vb == (s == 0)) ? 4'h8 : 4'hC;
			a = {32'h0000_7770, c ^ 4'(s)};
			i_dev.send(c, a, 4'hF, vb && c == 4'h8, ok, cf);
			check(ok, 1'b1);
			check(rq_cmd, c);
			check(rq_addr, (vb && s == 1) ? {a[35:2], 2'b00} : a);
		end
		check(wr_q.size(), 4);
	endtask : t_victim
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		clock_i = 1'b0;
		rst_b_i = 1'b0;
		wr_ready_i = 1'b1;
		cond_fail_i = 1'b0;
		fill_start_i = 1'b0;
		fill_slot_i = 1'b0;
		fill_shared_i = 1'b0;
		fill_data_i = 128'h0;
		fill_valid_i = 1'b0;
		repeat (5) @(posedge clock_i);
		t_reset();
		#1;
		rst_b_i = 1'b1;
		t_plain();
		t_wb();
		t_fill(4'hA, 1'b0);
		t_fill(4'h9, 1'b1);
		t_blk();
		t_victim(1'b1);
		t_victim(1'b0);
		close_out();
	end
endmodule : sbc_host_tb
